//--- pkg/reading_math_pkg.sv
`default_nettype none

package reading_math_pkg;

  // -------------------------------------------------------------------------
  // Register map (byte addresses)
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_FUNCTION = 8'h04;
  localparam logic [7:0] ADDR_TRIGGER = 8'h08;
  localparam logic [7:0] ADDR_HOLD_BAND = 8'h0c;
  localparam logic [7:0] ADDR_REF_RES = 8'h10;
  localparam logic [7:0] ADDR_COMMA = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;
  localparam logic [7:0] ADDR_MINIMUM = 8'h1c;
  localparam logic [7:0] ADDR_MAXIMUM = 8'h20;
  localparam logic [7:0] ADDR_AVERAGE = 8'h24;
  localparam logic [7:0] ADDR_COUNT = 8'h28;
  localparam logic [7:0] ADDR_OFFSET = 8'h2c;
  localparam logic [7:0] ADDR_DECIBEL_RELATIVE_SETTING = 8'h30;
  localparam logic [7:0] ADDR_HOLD = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;

  // -------------------------------------------------------------------------
  // Control register bit positions
  // -------------------------------------------------------------------------
  localparam int EN_OFFSET = 0;
  localparam int EN_EXTREME = 1;
  localparam int EN_REL_DB = 2;
  localparam int EN_POWER_DB = 3;
  localparam int EN_HOLD = 4;
  localparam int EN_WIDTH = 5;

  // -------------------------------------------------------------------------
  // Measurement function codes
  // -------------------------------------------------------------------------
  localparam logic [3:0] FUNC_DC_VOLTAGE = 4'h0;
  localparam logic [3:0] FUNC_ALTERNATING_VOLTAGE = 4'h1;
  localparam logic [3:0] FUNC_DC_CURRENT = 4'h2;
  localparam logic [3:0] FUNC_AC_CURRENT = 4'h3;
  localparam logic [3:0] FUNC_RES_2W = 4'h4;
  localparam logic [3:0] FUNC_RES_4W = 4'h5;
  localparam logic [3:0] FUNC_FREQUENCY = 4'h6;
  localparam logic [3:0] FUNC_PERIOD = 4'h7;
  localparam logic [3:0] FUNC_CONTINUITY = 4'h8;
  localparam logic [3:0] FUNC_DIODE = 4'h9;
  localparam logic [3:0] FUNC_QUOTIENT = 4'ha;
  localparam logic [3:0] FUNC_LAST = 4'ha;

  // -------------------------------------------------------------------------
  // Trigger modes, hold bands, reset values
  // -------------------------------------------------------------------------
  localparam logic [1:0] TRIG_AUTO = 2'h0;
  localparam logic [1:0] TRIG_SINGLE = 2'h1;
  localparam logic [1:0] TRIG_EXTERNAL = 2'h2;

  localparam logic [1:0] BAND_DEFAULT = 2'h1;
  localparam logic [15:0] BAND_BASIS_POINTS [0:3] = '{16'h0001, 16'h000a, 16'h0064, 16'h03e8};
  localparam logic [63:0] BASIS_POINT_SCALE = 64'h0000_0000_0000_2710;

  localparam int REF_COUNT = 17;
  localparam logic [4:0] REF_DEFAULT = 5'h0b;
  localparam logic [4:0] REF_LAST = 5'h10;
  // Ten times log10 of each reference resistance, in hundredths of a decibel.
  localparam logic [15:0] REF_LOSS_CENTI_DB [0:REF_COUNT-1] = '{
    16'h06a3, 16'h0753, 16'h07b0, 16'h07f9, 16'h082d, 16'h0831, 16'h0852, 16'h0880,
    16'h095e, 16'h09ad, 16'h0a8b, 16'h0ada, 16'h0b57, 16'h0b8a, 16'h0bb8, 16'h0c07,
    16'h0f3f};
  localparam logic COMMA_DEFAULT = 1'b1;

  // Readings are micro-units; 20*log10(2) = 6.0206 dB per octave in centi-dB.
  localparam logic [31:0] CENTI_DB_PER_OCTAVE = 32'h0000_025a;
  // Micro-volt squared over one milliwatt: -120 dB + 30 dB, in centi-dB.
  localparam logic signed [31:0] POWER_DB_SHIFT = 32'sh0000_2328;
  localparam logic signed [63:0] QUOTIENT_SCALE = 64'sh0000_0000_000f_4240;
  localparam logic [1:0] HOLD_STABLE_COUNT = 2'h3;

endpackage : reading_math_pkg

`default_nettype wire

//--- hw/reading_math_trigger_unit.sv
// Design decisions made here: the register offsets and register access over AHB-Lite.
`default_nettype none

module reading_math_trigger_unit #(
  parameter int DATA_WIDTH = 32
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic reading_valid,
  input wire logic signed [DATA_WIDTH-1:0] reading_value,
  input wire logic signed [DATA_WIDTH-1:0] reference_value,
  input wire logic power_loss,
  input wire logic remote_reset,
  input wire logic remote_mode,
  input wire logic single_key,
  input wire logic ext_trigger,
  output logic measure_start,
  output logic sample_active,
  output logic [3:0] measure_function,
  output logic reference_autorange,
  output logic result_valid,
  output logic signed [DATA_WIDTH-1:0] result_value,
  output logic signed [DATA_WIDTH-1:0] display_value,
  output logic hold_beep,
  output logic comma_enable
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef enum logic {
    TRIG_IDLE,
    TRIG_BUSY
  } trig_state_e;

  typedef struct packed {
    trig_state_e trig_state;
    logic start;
    logic ext_prev;
    logic [1:0] trig_mode;
    logic [3:0] func;
    logic [reading_math_pkg::EN_WIDTH-1:0] enables;
    logic offset_armed;
    logic rel_armed;
    logic signed [DATA_WIDTH-1:0] offset;
    logic signed [DATA_WIDTH-1:0] rel;
    logic signed [DATA_WIDTH-1:0] result;
    logic result_valid;
    logic signed [DATA_WIDTH-1:0] minimum;
    logic signed [DATA_WIDTH-1:0] maximum;
    logic signed [DATA_WIDTH-1:0] average;
    logic [31:0] count;
    logic signed [63:0] sum;
    logic signed [DATA_WIDTH-1:0] last;
    logic signed [DATA_WIDTH-1:0] held;
    logic [1:0] stable_count;
    logic beep;
    logic [1:0] band;
    logic [4:0] ref_index;
    logic comma;
    logic write_pending;
    logic [7:0] write_addr;
    logic [31:0] rdata;
  } unit_state_s;

  unit_state_s st;
  unit_state_s next_st;

  // -------------------------------------------------------------------------
  // Arithmetic helpers
  // -------------------------------------------------------------------------
  function automatic logic signed [DATA_WIDTH-1:0] power_db_of(
    input logic signed [DATA_WIDTH-1:0] r,
    input logic [4:0] idx
  );
    logic [31:0] mag;
    logic [4:0] msb;
    logic [31:0] norm;
    logic [12:0] log2_fix;
    logic [31:0] prod;
    mag = r[DATA_WIDTH-1] ? 32'(-r) : 32'(r);
    msb = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (mag[i])
      begin
        msb = 5'(i);
      end
    end
    norm = mag << (5'h1f - msb);
    log2_fix = {msb, norm[30:23]};
    prod = 32'(log2_fix) * reading_math_pkg::CENTI_DB_PER_OCTAVE;
    return DATA_WIDTH'($signed(prod >> 8) - reading_math_pkg::POWER_DB_SHIFT
      - $signed({16'h0000, reading_math_pkg::REF_LOSS_CENTI_DB[idx]}));
  endfunction : power_db_of

  function automatic logic within_band(
    input logic signed [DATA_WIDTH-1:0] a,
    input logic signed [DATA_WIDTH-1:0] b,
    input logic [1:0] band
  );
    logic signed [63:0] diff;
    logic [63:0] mag_diff;
    logic [63:0] mag_b;
    diff = 64'(a) - 64'(b);
    mag_diff = diff[63] ? 64'(-diff) : 64'(diff);
    mag_b = b[DATA_WIDTH-1] ? 64'(-64'(b)) : 64'(b);
    return (mag_diff * reading_math_pkg::BASIS_POINT_SCALE)
      <= (mag_b * 64'(reading_math_pkg::BAND_BASIS_POINTS[band]));
  endfunction : within_band

  function automatic logic is_voltage(input logic [3:0] f);
    return (f == reading_math_pkg::FUNC_DC_VOLTAGE)
      || (f == reading_math_pkg::FUNC_ALTERNATING_VOLTAGE);
  endfunction : is_voltage

  function automatic logic offset_allowed(input logic [3:0] f);
    return (f != reading_math_pkg::FUNC_CONTINUITY) && (f != reading_math_pkg::FUNC_DIODE)
      && (f != reading_math_pkg::FUNC_QUOTIENT);
  endfunction : offset_allowed

  function automatic logic extreme_allowed(input logic [3:0] f);
    return (f != reading_math_pkg::FUNC_CONTINUITY) && (f != reading_math_pkg::FUNC_DIODE);
  endfunction : extreme_allowed

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  logic signed [DATA_WIDTH-1:0] v;
  logic signed [DATA_WIDTH-1:0] db_val;
  logic signed [63:0] quot;
  logic signed [63:0] new_sum;
  logic [31:0] new_count;
  localparam int EN_W = reading_math_pkg::EN_WIDTH;
  logic [EN_W-1:0] wen;
  logic trigger_now;

  always_comb
  begin
    next_st = st;
    next_st.start = 1'b0;
    next_st.beep = 1'b0;
    next_st.result_valid = 1'b0;
    next_st.ext_prev = ext_trigger;
    v = reading_value;
    db_val = '0;
    quot = '0;
    new_sum = '0;
    new_count = '0;
    wen = '0;

    // Trigger sequencing.
    trigger_now = 1'b0;
    case (st.trig_mode)
      reading_math_pkg::TRIG_AUTO: trigger_now = 1'b1;
      reading_math_pkg::TRIG_SINGLE: trigger_now = single_key && !remote_mode;
      reading_math_pkg::TRIG_EXTERNAL: trigger_now = st.ext_prev && !ext_trigger;
      default: trigger_now = 1'b0;
    endcase
    case (st.trig_state)
      TRIG_IDLE:
      begin
        if (trigger_now)
        begin
          next_st.start = 1'b1;
          next_st.trig_state = TRIG_BUSY;
        end
      end
      TRIG_BUSY:
      begin
        if (reading_valid)
        begin
          next_st.trig_state = TRIG_IDLE;
        end
      end
      default: next_st.trig_state = TRIG_IDLE;
    endcase

    // Reading processing chain.
    if (reading_valid)
    begin
      if (st.func == reading_math_pkg::FUNC_QUOTIENT)
      begin
        if (reference_value == '0)
        begin
          quot = reading_value[DATA_WIDTH-1] ? 64'sh8000_0000 : 64'sh7fff_ffff;
        end
        else
        begin
          quot = (64'(reading_value) * reading_math_pkg::QUOTIENT_SCALE)
            / 64'(reference_value);
        end
        v = DATA_WIDTH'(quot);
      end
      if (st.enables[reading_math_pkg::EN_OFFSET])
      begin
        if (st.offset_armed)
        begin
          next_st.offset = reading_value;
          next_st.offset_armed = 1'b0;
        end
        v = v - next_st.offset;
      end
      if (st.enables[reading_math_pkg::EN_POWER_DB] || st.enables[reading_math_pkg::EN_REL_DB])
      begin
        db_val = power_db_of(v, st.ref_index);
        v = db_val;
        if (st.enables[reading_math_pkg::EN_REL_DB])
        begin
          if (st.rel_armed)
          begin
            next_st.rel = db_val;
            next_st.rel_armed = 1'b0;
          end
          v = db_val - next_st.rel;
        end
      end
      next_st.result = v;
      next_st.result_valid = 1'b1;
      if (st.enables[reading_math_pkg::EN_EXTREME])
      begin
        new_count = st.count + 32'h0000_0001;
        new_sum = st.sum + 64'(v);
        if (st.count == '0 || v < st.minimum)
        begin
          next_st.minimum = v;
        end
        if (st.count == '0 || v > st.maximum)
        begin
          next_st.maximum = v;
        end
        next_st.count = new_count;
        next_st.sum = new_sum;
        next_st.average = DATA_WIDTH'(new_sum / $signed({32'h0000_0000, new_count}));
      end
      if (st.enables[reading_math_pkg::EN_HOLD])
      begin
        next_st.last = v;
        if (st.stable_count != 2'h0 && within_band(v, st.last, st.band))
        begin
          next_st.stable_count = st.stable_count + 2'h1;
        end
        else
        begin
          next_st.stable_count = 2'h1;
        end
        if (next_st.stable_count == reading_math_pkg::HOLD_STABLE_COUNT)
        begin
          next_st.held = v;
          next_st.beep = 1'b1;
          next_st.stable_count = 2'h0;
        end
      end
    end

    // Bus slave: address phase, then write in the data phase.
    if (st.write_pending)
    begin
      next_st.write_pending = 1'b0;
      case (st.write_addr)
        reading_math_pkg::ADDR_CONTROL:
        begin
          wen = hwdata[EN_W-1:0];
          if (!offset_allowed(st.func))
          begin
            wen[reading_math_pkg::EN_OFFSET] = 1'b0;
          end
          if (!extreme_allowed(st.func))
          begin
            wen[reading_math_pkg::EN_EXTREME] = 1'b0;
          end
          if (!is_voltage(st.func))
          begin
            wen[reading_math_pkg::EN_REL_DB] = 1'b0;
            wen[reading_math_pkg::EN_POWER_DB] = 1'b0;
          end
          if (wen[reading_math_pkg::EN_OFFSET] != st.enables[reading_math_pkg::EN_OFFSET])
          begin
            next_st.offset = '0;
            next_st.offset_armed = wen[reading_math_pkg::EN_OFFSET];
          end
          if (wen[reading_math_pkg::EN_EXTREME] != st.enables[reading_math_pkg::EN_EXTREME])
          begin
            next_st.minimum = '0;
            next_st.maximum = '0;
            next_st.average = '0;
            next_st.count = '0;
            next_st.sum = '0;
          end
          if (wen[reading_math_pkg::EN_REL_DB] != st.enables[reading_math_pkg::EN_REL_DB])
          begin
            next_st.rel = '0;
            next_st.rel_armed = wen[reading_math_pkg::EN_REL_DB];
          end
          if (wen[reading_math_pkg::EN_HOLD] && !st.enables[reading_math_pkg::EN_HOLD])
          begin
            next_st.stable_count = 2'h0;
          end
          next_st.enables = wen;
        end
        reading_math_pkg::ADDR_FUNCTION:
        begin
          if (hwdata[3:0] <= reading_math_pkg::FUNC_LAST && hwdata[3:0] != st.func)
          begin
            next_st.func = hwdata[3:0];
            next_st.enables[reading_math_pkg::EN_OFFSET] = 1'b0;
            next_st.enables[reading_math_pkg::EN_EXTREME] = 1'b0;
            next_st.enables[reading_math_pkg::EN_REL_DB] = 1'b0;
            if (!is_voltage(hwdata[3:0]))
            begin
              next_st.enables[reading_math_pkg::EN_POWER_DB] = 1'b0;
            end
            next_st.offset = '0;
            next_st.offset_armed = 1'b0;
            next_st.rel = '0;
            next_st.rel_armed = 1'b0;
            next_st.minimum = '0;
            next_st.maximum = '0;
            next_st.average = '0;
            next_st.count = '0;
            next_st.sum = '0;
          end
        end
        reading_math_pkg::ADDR_TRIGGER:
        begin
          if (hwdata[1:0] != 2'h3)
          begin
            next_st.trig_mode = hwdata[1:0];
          end
        end
        reading_math_pkg::ADDR_HOLD_BAND: next_st.band = hwdata[1:0];
        reading_math_pkg::ADDR_REF_RES:
        begin
          if (hwdata[4:0] <= reading_math_pkg::REF_LAST)
          begin
            next_st.ref_index = hwdata[4:0];
          end
        end
        reading_math_pkg::ADDR_COMMA: next_st.comma = hwdata[0];
        default: next_st.write_pending = 1'b0;
      endcase
    end
    if (hsel && hready && htrans[1])
    begin
      next_st.write_pending = hwrite;
      next_st.write_addr = haddr[7:0];
      next_st.rdata = '0;
      if (!hwrite)
      begin
        case (haddr[7:0])
          reading_math_pkg::ADDR_CONTROL: next_st.rdata = 32'(st.enables);
          reading_math_pkg::ADDR_FUNCTION: next_st.rdata = 32'(st.func);
          reading_math_pkg::ADDR_TRIGGER: next_st.rdata = 32'(st.trig_mode);
          reading_math_pkg::ADDR_HOLD_BAND: next_st.rdata = 32'(st.band);
          reading_math_pkg::ADDR_REF_RES: next_st.rdata = 32'(st.ref_index);
          reading_math_pkg::ADDR_COMMA: next_st.rdata = 32'(st.comma);
          reading_math_pkg::ADDR_RESULT: next_st.rdata = 32'(st.result);
          reading_math_pkg::ADDR_MINIMUM: next_st.rdata = 32'(st.minimum);
          reading_math_pkg::ADDR_MAXIMUM: next_st.rdata = 32'(st.maximum);
          reading_math_pkg::ADDR_AVERAGE: next_st.rdata = 32'(st.average);
          reading_math_pkg::ADDR_COUNT: next_st.rdata = st.count;
          reading_math_pkg::ADDR_OFFSET: next_st.rdata = 32'(st.offset);
          reading_math_pkg::ADDR_DECIBEL_RELATIVE_SETTING: next_st.rdata = 32'(st.rel);
          reading_math_pkg::ADDR_HOLD: next_st.rdata = 32'(st.held);
          reading_math_pkg::ADDR_STATUS:
            next_st.rdata = {26'h0, remote_mode, st.rel_armed, st.offset_armed,
              st.stable_count, st.trig_state == TRIG_BUSY};
          default: next_st.rdata = '0;
        endcase
      end
    end

    // Power loss and remote reset clear volatile state only.
    if (power_loss || remote_reset)
    begin
      next_st.enables = '0;
      next_st.offset = '0;
      next_st.offset_armed = 1'b0;
      next_st.rel = '0;
      next_st.rel_armed = 1'b0;
      next_st.minimum = '0;
      next_st.maximum = '0;
      next_st.average = '0;
      next_st.count = '0;
      next_st.sum = '0;
      next_st.stable_count = 2'h0;
      next_st.held = '0;
      next_st.band = reading_math_pkg::BAND_DEFAULT;
      next_st.trig_mode = reading_math_pkg::TRIG_AUTO;
      next_st.func = reading_math_pkg::FUNC_DC_VOLTAGE;
      next_st.trig_state = TRIG_IDLE;
      next_st.start = 1'b0;
      // Reference resistance and separator are left untouched.
    end
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
      st.band <= reading_math_pkg::BAND_DEFAULT;
      st.ref_index <= reading_math_pkg::REF_DEFAULT;
      st.comma <= reading_math_pkg::COMMA_DEFAULT;
      st.trig_mode <= reading_math_pkg::TRIG_AUTO;
    end
    else
    begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign measure_start = st.start;
  assign sample_active = (st.trig_state == TRIG_BUSY);
  assign measure_function = st.func;
  assign reference_autorange = (st.func == reading_math_pkg::FUNC_QUOTIENT);
  assign result_valid = st.result_valid;
  assign result_value = st.result;
  assign display_value = st.enables[reading_math_pkg::EN_HOLD] ? st.held : st.result;
  assign hold_beep = st.beep;
  assign comma_enable = st.comma;

endmodule : reading_math_trigger_unit

`default_nettype wire

//--- dv/reading_front_end.sv
`default_nettype none
module reading_front_end (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic measure_start,
  input wire logic slow,
  input wire logic signed [31:0] value_in,
  output logic reading_valid,
  output logic signed [31:0] reading_value,
  output logic signed [31:0] reference_value
);
  timeunit 1ns;
  timeprecision 1ns;
  int left;
  // Between strobes the data lines flip so a stale value never looks valid.
  always @(posedge core_clk or posedge reset)
    if (reset)
    begin
      left <= 0;
      reading_valid <= 1'b0;
      reading_value <= 32'sh0;
      reference_value <= 32'sh0;
    end
    else
    begin
      reading_valid <= 1'b0;
      reading_value <= ~reading_value;
      reference_value <= ~reference_value;
      left <= measure_start ? (slow ? 6 : 2) : (left > 0 ? left - 1 : 0);
      if (!measure_start && left == 1)
      begin
        reading_valid <= 1'b1;
        reading_value <= value_in;
        reference_value <= value_in + 32'sh1;
      end
    end
endmodule : reading_front_end
`default_nettype wire

//--- dv/reading_math_trigger_unit_checker.sv
`default_nettype none
module reading_math_trigger_unit_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic reading_valid,
  input wire logic power_loss,
  input wire logic measure_start,
  input wire logic sample_active,
  input wire logic [3:0] measure_function,
  input wire logic reference_autorange,
  input wire logic result_valid,
  input wire logic hold_beep,
  input wire logic comma_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not okay");
  property p_start; measure_start |=> !measure_start; endproperty
  a_start: assert property (p_start) else $error("start too long");
  property p_busy; sample_active && $past(sample_active) |-> !measure_start; endproperty
  a_busy: assert property (p_busy) else $error("start while busy");
  property p_lamp; measure_start |-> sample_active; endproperty
  a_lamp: assert property (p_lamp) else $error("sample lamp off");
  property p_end; result_valid |-> !sample_active; endproperty
  a_end: assert property (p_end) else $error("sample lamp stuck");
  property p_res; reading_valid |=> result_valid; endproperty
  a_res: assert property (p_res) else $error("result missing");
  property p_cause; result_valid |-> $past(reading_valid); endproperty
  a_cause: assert property (p_cause) else $error("result without reading");
  property p_auto;
    reference_autorange == (measure_function == reading_math_pkg::FUNC_QUOTIENT);
  endproperty
  a_auto: assert property (p_auto) else $error("autorange wrong");
  property p_beep; hold_beep |-> result_valid ##1 !hold_beep; endproperty
  a_beep: assert property (p_beep) else $error("beep wrong");
  property p_comma; power_loss |=> comma_enable == $past(comma_enable); endproperty
  a_comma: assert property (p_comma) else $error("separator lost");
endmodule : reading_math_trigger_unit_checker
bind reading_math_trigger_unit reading_math_trigger_unit_checker checker_inst (.core_clk,
  .reset, .hreadyout, .hresp, .reading_valid, .power_loss, .measure_start, .sample_active,
  .measure_function, .reference_autorange, .result_valid, .hold_beep, .comma_enable);
`default_nettype wire

//--- dv/reading_math_trigger_unit_tb.sv
`default_nettype none
module reading_math_trigger_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset, hsel, hwrite, hready, hreadyout, hresp, reading_valid, power_loss;
  logic remote_reset, remote_mode, single_key, ext_trigger, measure_start, sample_active, slow;
  logic reference_autorange, result_valid, hold_beep, comma_enable;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] measure_function;
  logic signed [31:0] reading_value, reference_value, result_value, display_value, rnd;
  int fails, checks_done, nres, n0;
  bit off_en, off_arm, ext_en, fix, db_en, q_en;
  longint off, mn, mx, sum, cnt, r_last, ref_last, e;
  reading_math_trigger_unit reading_math_trigger_unit_inst (.core_clk, .reset, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .reading_valid,
    .reading_value, .reference_value, .power_loss, .remote_reset, .remote_mode, .single_key,
    .ext_trigger, .measure_start, .sample_active, .measure_function, .reference_autorange,
    .result_valid, .result_value, .display_value, .hold_beep, .comma_enable);
  reading_front_end reading_front_end_inst (.core_clk, .reset, .measure_start, .slow,
    .value_in(rnd), .reading_valid, .reading_value, .reference_value);
  assign hready = hreadyout;
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    rnd <= fix ? 32'h0007_a120 : 32'($urandom_range(1000000, 1));
    slow <= 1'($urandom_range(1, 0));
  end
  always @(posedge core_clk)
  begin
    if (result_valid === 1'b1)
    begin
      nres++;
      e = q_en ? r_last * reading_math_pkg::QUOTIENT_SCALE / ref_last : r_last;
      if (off_en && off_arm) off = e;
      off_arm = 1'b0;
      e = off_en ? e - off : e;
      e = db_en ? 0 : e;
      mn = (ext_en && (cnt == 0 || e < mn)) ? e : mn;
      mx = (ext_en && (cnt == 0 || e > mx)) ? e : mx;
      sum += ext_en ? e : 0;
      cnt += ext_en ? 1 : 0;
      cmp(result_value, e[31:0]);
    end
    if (reading_valid === 1'b1)
    begin
      r_last = reading_value;
      ref_last = reference_value;
    end
  end
  task cmp(input logic [31:0] g, input logic [31:0] w);
    checks_done++;
    if (g !== w)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, w);
    end
  endtask : cmp
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    n = 0;
    do @(posedge core_clk); while (hready !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1 && ++n < 50);
    q = hrdata;
    if (n >= 50)
    begin
      fails++;
      give_verdict();
    end
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] w);
    bus(1'b0, a, 32'h0);
    cmp(q, w);
  endtask : rd
  task press(input logic [31:0] want);
    n0 = nres;
    @(posedge core_clk);
    single_key <= 1'b1;
    @(posedge core_clk);
    single_key <= 1'b0;
    repeat (30) @(posedge core_clk);
    cmp(32'(nres - n0), want);
  endtask : press
  initial
  begin
    {hsel, haddr, htrans, hwrite, hwdata, power_loss, remote_reset, remote_mode} = '0;
    {single_key, ext_trigger, fix, db_en, q_en} = '0;
    hsize = 3'h2;
    reset = 1'b1;
    void'($urandom(32'h4ed3));
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h14, 32'(reading_math_pkg::COMMA_DEFAULT));
    rd(8'h10, 32'(reading_math_pkg::REF_DEFAULT));
    rd(8'h0c, 32'(reading_math_pkg::BAND_DEFAULT));
    rd(8'h08, 32'(reading_math_pkg::TRIG_AUTO));
    repeat (60) @(posedge core_clk);
    cmp(32'(nres > 2), 32'h1);
    bus(1'b1, 8'h08, 32'(reading_math_pkg::TRIG_SINGLE));
    repeat (20) @(posedge core_clk);
    bus(1'b1, 8'h00, 32'h1);
    {off_en, off_arm} = 2'b11;
    repeat (3) press(32'h1);
    rd(8'h2c, off[31:0]);
    remote_mode <= 1'b1;
    press(32'h0);
    remote_mode <= 1'b0;
    bus(1'b1, 8'h00, 32'h2);
    {off_en, ext_en, off} = {2'b01, 64'h0};
    rd(8'h2c, 32'h0);
    repeat (4) press(32'h1);
    rd(8'h1c, mn[31:0]);
    rd(8'h20, mx[31:0]);
    rd(8'h24, 32'(sum / cnt));
    rd(8'h28, cnt[31:0]);
    bus(1'b1, 8'h00, 32'h3);
    {off_en, off_arm} = 2'b11;
    press(32'h1);
    bus(1'b1, 8'h04, 32'(reading_math_pkg::FUNC_ALTERNATING_VOLTAGE));
    {off_en, ext_en, mn, mx, sum, cnt} = '0;
    rd(8'h00, 32'h0);
    rd(8'h2c, 32'h0);
    rd(8'h28, 32'h0);
    bus(1'b1, 8'h04, 32'(reading_math_pkg::FUNC_DIODE));
    bus(1'b1, 8'h00, 32'h3);
    rd(8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'(reading_math_pkg::FUNC_QUOTIENT));
    q_en = 1'b1;
    press(32'h1);
    q_en = 1'b0;
    bus(1'b1, 8'h04, 32'(reading_math_pkg::FUNC_DC_VOLTAGE));
    rd(8'h04, 32'(reading_math_pkg::FUNC_DC_VOLTAGE));
    $display("math tests done");
    fix = 1'b1;
    bus(1'b1, 8'h00, 32'h10);
    repeat (4) press(32'h1);
    cmp(display_value, 32'h0007_a120);
    bus(1'b1, 8'h00, 32'h4);
    db_en = 1'b1;
    repeat (2) press(32'h1);
    bus(1'b0, 8'h30, 32'h0);
    cmp(32'($signed(q) > -420 && $signed(q) < -340), 32'h1);
    bus(1'b1, 8'h00, 32'h0);
    db_en = 1'b0;
    rd(8'h30, 32'h0);
    bus(1'b1, 8'h08, 32'(reading_math_pkg::TRIG_EXTERNAL));
    n0 = nres;
    ext_trigger <= 1'b1;
    repeat (10) @(posedge core_clk);
    cmp(32'(nres - n0), 32'h0);
    ext_trigger <= 1'b0;
    repeat (30) @(posedge core_clk);
    cmp(32'(nres - n0), 32'h1);
    $display("trigger tests done");
    bus(1'b1, 8'h10, 32'h3);
    bus(1'b1, 8'h10, 32'h11);
    rd(8'h10, 32'h3);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h0c, 32'h2);
    power_loss <= 1'b1;
    @(posedge core_clk);
    power_loss <= 1'b0;
    rd(8'h10, 32'h3);
    rd(8'h0c, 32'(reading_math_pkg::BAND_DEFAULT));
    rd(8'h08, 32'(reading_math_pkg::TRIG_AUTO));
    remote_reset <= 1'b1;
    @(posedge core_clk);
    remote_reset <= 1'b0;
    rd(8'h14, 32'h0);
    cmp(32'(comma_enable), 32'h0);
    $display("retention tests done");
    give_verdict();
  end
endmodule : reading_math_trigger_unit_tb
`default_nettype wire
